// [inc/agcc_pkg.sv]
// Shared constants and types for the gain and cathode configuration bank.
package agcc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_LEGACY_CFG = 8'h3c;
  localparam logic [7:0] IDX_SLOTA_CFG = 8'h42;
  localparam logic [7:0] IDX_SLOTB_CFG = 8'h44;
  localparam logic [7:0] IDX_CATH_CFG = 8'h54;
  localparam logic [7:0] IDX_GAIN_SEL = 8'h55;
  localparam logic [7:0] IDX_STATUS = 8'h60;

  // Reset values.
  localparam logic [15:0] RST_LEGACY_CFG = 16'h3006;
  localparam logic [15:0] RST_SLOTA_CFG = 16'h1c30;
  localparam logic [15:0] RST_SLOTB_CFG = 16'h1c30;
  localparam logic [15:0] RST_CATH_CFG = 16'h0020;
  localparam logic [15:0] RST_GAIN_SEL = 16'h0000;

  // Field positions.
  localparam int POS_LEGACY_CATH = 9;
  localparam int POS_IND_EN = 6;
  localparam int POS_COMMON_GAIN = 0;
  localparam int POS_SLEEP_CATH = 12;
  localparam int POS_SLOTB_CATH = 10;
  localparam int POS_SLOTA_CATH = 8;
  localparam int POS_CATH_SEL = 7;
  localparam int POS_B_CH4 = 10;
  localparam int POS_B_CH3 = 8;
  localparam int POS_B_CH2 = 6;
  localparam int POS_A_CH4 = 4;
  localparam int POS_A_CH3 = 2;
  localparam int POS_A_CH2 = 0;

  // Operating state of the front end, one-hot.
  typedef enum logic [2:0] {
    OPST_SLEEP = 3'h1,
    OPST_SLOTA = 3'h2,
    OPST_SLOTB = 3'h4
  } agcc_opst_e;

  // Bus handshake states.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } agcc_bus_e;

  // Transimpedance gain codes: 0 200k, 1 100k, 2 50k, 3 25k ohm.
  typedef logic [1:0] agcc_gain_t;

  typedef struct packed {
    agcc_gain_t ch4;
    agcc_gain_t ch3;
    agcc_gain_t ch2;
    agcc_gain_t ch1;
  } agcc_gain_s;

  typedef struct packed {
    logic use_fields;
    logic legacy_bias;
    logic [1:0] code;
  } agcc_cath_s;

endpackage

// [core/agcc_top.sv]
// Gain and cathode configuration register bank with Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none

module agcc_top (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Avalon-MM slave.
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Operating state of the front end.
  input wire agcc_pkg::agcc_opst_e OP_STATE,
  // Effective settings.
  output agcc_pkg::agcc_cath_s CATH_OUT,
  output agcc_pkg::agcc_gain_s SLOTA_GAIN,
  output agcc_pkg::agcc_gain_s SLOTB_GAIN
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: waitrequest rests high and drops for one cycle per access.

  agcc_pkg::agcc_bus_e bus_q;
  logic req;
  logic take;
  logic word_ok;
  logic [7:0] idx;

  assign req = AVS_READ | AVS_WRITE;
  assign take = req && (bus_q == agcc_pkg::BUS_IDLE);
  assign word_ok = (AVS_ADDRESS[1:0] == 2'h0);
  assign idx = AVS_ADDRESS[9:2];

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= agcc_pkg::BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      unique case (bus_q)
        agcc_pkg::BUS_IDLE: begin
          if (req) begin
            bus_q <= agcc_pkg::BUS_ACK;
            AVS_WAITREQUEST <= 1'b0;
          end
        end
        agcc_pkg::BUS_ACK: begin
          bus_q <= agcc_pkg::BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
        default: begin
          bus_q <= agcc_pkg::BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [15:0] legacy_cfg_q;
  logic [15:0] slota_cfg_q;
  logic [15:0] slotb_cfg_q;
  logic [15:0] cath_cfg_q;
  logic [15:0] gain_sel_q;
  logic wr;

  // A write lands only at the edge where waitrequest is low, when the master sees the access complete.
  assign wr = (bus_q == agcc_pkg::BUS_ACK) && AVS_WRITE && word_ok;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [1:0] be, input logic [15:0] wd);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      legacy_cfg_q <= agcc_pkg::RST_LEGACY_CFG;
      slota_cfg_q <= agcc_pkg::RST_SLOTA_CFG;
      slotb_cfg_q <= agcc_pkg::RST_SLOTB_CFG;
      cath_cfg_q <= agcc_pkg::RST_CATH_CFG;
      gain_sel_q <= agcc_pkg::RST_GAIN_SEL;
    end else if (wr) begin
      if (idx == agcc_pkg::IDX_LEGACY_CFG) begin
        legacy_cfg_q <= merge(legacy_cfg_q, AVS_BYTEENABLE[1:0], AVS_WRITEDATA[15:0]);
      end
      if (idx == agcc_pkg::IDX_SLOTA_CFG) begin
        slota_cfg_q <= merge(slota_cfg_q, AVS_BYTEENABLE[1:0], AVS_WRITEDATA[15:0]);
      end
      if (idx == agcc_pkg::IDX_SLOTB_CFG) begin
        slotb_cfg_q <= merge(slotb_cfg_q, AVS_BYTEENABLE[1:0], AVS_WRITEDATA[15:0]);
      end
      if (idx == agcc_pkg::IDX_CATH_CFG) begin
        cath_cfg_q <= merge(cath_cfg_q, AVS_BYTEENABLE[1:0], AVS_WRITEDATA[15:0]);
      end
      if (idx == agcc_pkg::IDX_GAIN_SEL) begin
        gain_sel_q <= merge(gain_sel_q, AVS_BYTEENABLE[1:0], AVS_WRITEDATA[15:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective cathode and gain settings.

  agcc_pkg::agcc_cath_s cath_d;
  agcc_pkg::agcc_gain_s gain_a_d;
  agcc_pkg::agcc_gain_s gain_b_d;
  logic cath_sel;
  logic a_ind;
  logic b_ind;
  agcc_pkg::agcc_gain_t a_common;
  agcc_pkg::agcc_gain_t b_common;

  assign cath_sel = cath_cfg_q[agcc_pkg::POS_CATH_SEL];
  assign a_ind = slota_cfg_q[agcc_pkg::POS_IND_EN];
  assign b_ind = slotb_cfg_q[agcc_pkg::POS_IND_EN];
  assign a_common = slota_cfg_q[agcc_pkg::POS_COMMON_GAIN +: 2];
  assign b_common = slotb_cfg_q[agcc_pkg::POS_COMMON_GAIN +: 2];

  always_comb begin
    cath_d.use_fields = cath_sel;
    // Legacy bit only counts while the field group is not selected.
    cath_d.legacy_bias = cath_sel ? 1'b0 : legacy_cfg_q[agcc_pkg::POS_LEGACY_CATH];
    cath_d.code = 2'h0;
    if (cath_sel) begin
      unique case (OP_STATE)
        agcc_pkg::OPST_SLEEP: cath_d.code = cath_cfg_q[agcc_pkg::POS_SLEEP_CATH +: 2];
        agcc_pkg::OPST_SLOTA: cath_d.code = cath_cfg_q[agcc_pkg::POS_SLOTA_CATH +: 2];
        agcc_pkg::OPST_SLOTB: cath_d.code = cath_cfg_q[agcc_pkg::POS_SLOTB_CATH +: 2];
        default: cath_d.code = cath_cfg_q[agcc_pkg::POS_SLEEP_CATH +: 2];
      endcase
    end
  end

  always_comb begin
    // Channel 1 always follows the slot field; others depend on the enable.
    gain_a_d.ch1 = a_common;
    gain_a_d.ch2 = a_common;
    gain_a_d.ch3 = a_common;
    gain_a_d.ch4 = a_common;
    if (a_ind) begin
      gain_a_d.ch4 = gain_sel_q[agcc_pkg::POS_A_CH4 +: 2];
      gain_a_d.ch3 = gain_sel_q[agcc_pkg::POS_A_CH3 +: 2];
      gain_a_d.ch2 = gain_sel_q[agcc_pkg::POS_A_CH2 +: 2];
    end
  end

  always_comb begin
    gain_b_d.ch1 = b_common;
    gain_b_d.ch2 = b_common;
    gain_b_d.ch3 = b_common;
    gain_b_d.ch4 = b_common;
    if (b_ind) begin
      gain_b_d.ch4 = gain_sel_q[agcc_pkg::POS_B_CH4 +: 2];
      gain_b_d.ch3 = gain_sel_q[agcc_pkg::POS_B_CH3 +: 2];
      gain_b_d.ch2 = gain_sel_q[agcc_pkg::POS_B_CH2 +: 2];
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CATH_OUT <= '0;
      SLOTA_GAIN <= '0;
      SLOTB_GAIN <= '0;
    end else begin
      CATH_OUT <= cath_d;
      SLOTA_GAIN <= gain_a_d;
      SLOTB_GAIN <= gain_b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the cycle the access is taken.

  logic [15:0] rd_d;

  always_comb begin
    rd_d = 16'h0000;
    if (word_ok) begin
      if (idx == agcc_pkg::IDX_LEGACY_CFG) begin
        rd_d = legacy_cfg_q;
      end else if (idx == agcc_pkg::IDX_SLOTA_CFG) begin
        rd_d = slota_cfg_q;
      end else if (idx == agcc_pkg::IDX_SLOTB_CFG) begin
        rd_d = slotb_cfg_q;
      end else if (idx == agcc_pkg::IDX_CATH_CFG) begin
        rd_d = cath_cfg_q;
      end else if (idx == agcc_pkg::IDX_GAIN_SEL) begin
        rd_d = gain_sel_q;
      end else if (idx == agcc_pkg::IDX_STATUS) begin
        rd_d = {4'h0, CATH_OUT, SLOTB_GAIN.ch4, SLOTB_GAIN.ch3, SLOTA_GAIN.ch4, SLOTA_GAIN.ch3};
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (take && AVS_READ) begin
      AVS_READDATA <= {16'h0000, rd_d};
    end
  end

endmodule

`default_nettype wire

// [dv/agcc_top_chk.sv]
// Property checker for the gain and cathode configuration bank.
`timescale 1ns/1ps
`default_nettype none
module agcc_chk (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Avalon-MM slave.
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // State and effective settings.
  input wire agcc_pkg::agcc_opst_e OP_STATE,
  input wire agcc_pkg::agcc_cath_s CATH_OUT,
  input wire agcc_pkg::agcc_gain_s SLOTA_GAIN,
  input wire agcc_pkg::agcc_gain_s SLOTB_GAIN
);
  logic [15:0] l_q;
  logic [15:0] a_q;
  logic [15:0] b_q;
  logic [15:0] c_q;
  logic [15:0] g_q;
  logic take;
  logic [7:0] idx;
  // A write lands at the edge where waitrequest is seen low.
  assign take = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] == 2'h0;
  assign idx = AVS_ADDRESS[9:2];
  ////////////////////////////////////////////////////////////////
  // Shadow copies of the configuration registers, lane by lane.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      l_q <= agcc_pkg::RST_LEGACY_CFG;
      a_q <= agcc_pkg::RST_SLOTA_CFG;
      b_q <= agcc_pkg::RST_SLOTB_CFG;
      c_q <= agcc_pkg::RST_CATH_CFG;
      g_q <= agcc_pkg::RST_GAIN_SEL;
    end else if (take) begin
      for (int i = 0; i < 2; i++) begin
        if (AVS_BYTEENABLE[i]) begin
          if (idx == agcc_pkg::IDX_LEGACY_CFG) l_q[i*8+:8] <= AVS_WRITEDATA[i*8+:8];
          if (idx == agcc_pkg::IDX_SLOTA_CFG) a_q[i*8+:8] <= AVS_WRITEDATA[i*8+:8];
          if (idx == agcc_pkg::IDX_SLOTB_CFG) b_q[i*8+:8] <= AVS_WRITEDATA[i*8+:8];
          if (idx == agcc_pkg::IDX_CATH_CFG) c_q[i*8+:8] <= AVS_WRITEDATA[i*8+:8];
          if (idx == agcc_pkg::IDX_GAIN_SEL) g_q[i*8+:8] <= AVS_WRITEDATA[i*8+:8];
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ans;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  bus_answer_a: assert property (s_req |=> s_ans)
    else $error("access not answered within one cycle");
  read_upper_a: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0)
    else $error("read data upper half not zero");
  cath_select_a: assert property (CATH_OUT.use_fields == $past(c_q[agcc_pkg::POS_CATH_SEL]))
    else $error("cathode source does not follow select bit");
  legacy_code_a: assert property (!CATH_OUT.use_fields |-> CATH_OUT.code == 2'h0)
    else $error("field code driven in legacy mode");
  legacy_bit_a: assert property (!CATH_OUT.use_fields |-> CATH_OUT.legacy_bias == $past(l_q[9]))
    else $error("legacy cathode bit not followed");
  legacy_drop_a: assert property (CATH_OUT.use_fields |-> !CATH_OUT.legacy_bias)
    else $error("legacy bit not ignored");
  sleep_cath_a: assert property (CATH_OUT.use_fields && $past(OP_STATE) == agcc_pkg::OPST_SLEEP
    |-> CATH_OUT.code == $past(c_q[13:12]))
    else $error("sleep cathode field wrong");
  slota_cath_a: assert property (CATH_OUT.use_fields && $past(OP_STATE) == agcc_pkg::OPST_SLOTA
    |-> CATH_OUT.code == $past(c_q[9:8]))
    else $error("first slot cathode field wrong");
  slotb_cath_a: assert property (CATH_OUT.use_fields && $past(OP_STATE) == agcc_pkg::OPST_SLOTB
    |-> CATH_OUT.code == $past(c_q[11:10]))
    else $error("second slot cathode field wrong");
  slota_gain_a: assert property ($past(a_q[6]) |-> SLOTA_GAIN[7:2] == $past(g_q[5:0]))
    else $error("first slot channel gains wrong");
  slota_common_a: assert property (!$past(a_q[6]) |-> SLOTA_GAIN == {4{$past(a_q[1:0])}})
    else $error("first slot common gain not applied");
  slota_ch1_a: assert property (SLOTA_GAIN.ch1 == $past(a_q[1:0]))
    else $error("first slot channel 1 gain wrong");
  slotb_gain_a: assert property ($past(b_q[6]) |-> SLOTB_GAIN[7:2] == $past(g_q[11:6]))
    else $error("second slot channel gains wrong");
  slotb_common_a: assert property (!$past(b_q[6]) |-> SLOTB_GAIN == {4{$past(b_q[1:0])}})
    else $error("second slot common gain not applied");
  slotb_ch1_a: assert property (SLOTB_GAIN.ch1 == $past(b_q[1:0]))
    else $error("second slot channel 1 gain wrong");
endmodule
bind agcc_top agcc_chk u_chk (.CORE_CLK, .ARST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE,
  .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .OP_STATE, .CATH_OUT, .SLOTA_GAIN, .SLOTB_GAIN);
`default_nettype wire

// [dv/afe_gain_cathode_config_bench.sv]
// Self-checking bench for the gain and cathode configuration bank.
`timescale 1ns/1ps
`default_nettype none
module afe_gain_cathode_config_bench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [9:0] adr = 10'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [3:0] be = 4'h3;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  agcc_pkg::agcc_opst_e ops = agcc_pkg::OPST_SLEEP;
  agcc_pkg::agcc_cath_s cath;
  agcc_pkg::agcc_gain_s ga;
  agcc_pkg::agcc_gain_s gb;
  logic [31:0] got;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  agcc_top u_dut (.CORE_CLK(clk), .ARST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .OP_STATE(ops), .CATH_OUT(cath), .SLOTA_GAIN(ga), .SLOTB_GAIN(gb));
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus access; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= {idx, 2'h0};
    wd <= {16'h0, d};
    do @(posedge clk); while (wreq !== 1'h0);
    got = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ix [7] = '{agcc_pkg::IDX_LEGACY_CFG, agcc_pkg::IDX_SLOTA_CFG, agcc_pkg::IDX_SLOTB_CFG,
      agcc_pkg::IDX_CATH_CFG, agcc_pkg::IDX_GAIN_SEL, agcc_pkg::IDX_STATUS, 8'h10};
    logic [31:0] ev [7] = '{32'h3006, 32'h1c30, 32'h1c30, 32'h20, 32'h0, 32'h0, 32'h0};
    bus(1'h1, 8'h10, 16'hffff);
    bus(1'h1, agcc_pkg::IDX_STATUS, 16'hffff);
    for (int i = 0; i < 7; i++) begin
      bus(1'h0, ix[i], 16'h0);
      cmp(got, ev[i]);
    end
    $display("reset test done");
  endtask
  task automatic t_cath;
    bus(1'h1, agcc_pkg::IDX_LEGACY_CFG, 16'h3206);
    settle;
    cmp({28'h0, cath}, 32'h4);
    bus(1'h1, agcc_pkg::IDX_CATH_CFG, 16'h39a0);
    settle;
    cmp({28'h0, cath}, 32'hb);
    ops <= agcc_pkg::OPST_SLOTA;
    settle;
    cmp({28'h0, cath}, 32'h9);
    ops <= agcc_pkg::OPST_SLOTB;
    settle;
    cmp({28'h0, cath}, 32'ha);
    ops <= agcc_pkg::agcc_opst_e'(3'h3);
    settle;
    cmp({28'h0, cath}, 32'hb);
    ops <= agcc_pkg::OPST_SLEEP;
    bus(1'h1, agcc_pkg::IDX_CATH_CFG, 16'h0020);
    settle;
    cmp({28'h0, cath}, 32'h4);
    $display("cathode test done");
  endtask
  task automatic t_gain;
    bus(1'h1, agcc_pkg::IDX_GAIN_SEL, 16'h03b9);
    bus(1'h0, agcc_pkg::IDX_GAIN_SEL, 16'h0);
    cmp(got, 32'h3b9);
    bus(1'h1, agcc_pkg::IDX_SLOTA_CFG, 16'h1c32);
    bus(1'h1, agcc_pkg::IDX_SLOTB_CFG, 16'h1c31);
    settle;
    cmp({24'h0, ga}, 32'haa);
    cmp({24'h0, gb}, 32'h55);
    bus(1'h1, agcc_pkg::IDX_SLOTA_CFG, 16'h1c71);
    bus(1'h1, agcc_pkg::IDX_SLOTB_CFG, 16'h1c73);
    settle;
    cmp({24'h0, ga}, 32'he5);
    cmp({24'h0, gb}, 32'h3b);
    be <= 4'h1;
    bus(1'h1, agcc_pkg::IDX_GAIN_SEL, 16'hffff);
    be <= 4'h3;
    settle;
    cmp({24'h0, ga}, 32'hfd);
    cmp({24'h0, gb}, 32'h3f);
    bus(1'h0, agcc_pkg::IDX_STATUS, 16'h0);
    cmp(got, 32'h43f);
    $display("gain test done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    cmp({28'h0, cath}, 32'h0);
    t_reset;
    t_cath;
    t_gain;
    finish_test;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      finish_test;
    end
  end
endmodule
`default_nettype wire
